/* common/brk_wake_pkg.sv */
package brk_wake_pkg;

  // Bit positions of the control fields
  localparam int unsigned WAKE_EN_BIT = 1;
  localparam int unsigned SEND_BREAK_BIT = 3;
  localparam int unsigned TX_EN_BIT = 5;

  // Break frame: start bit plus twelve zeros, then stop
  localparam int unsigned BREAK_ZERO_BITS = 12;
  localparam int unsigned BREAK_LOW_BITS = BREAK_ZERO_BITS + 1;
  localparam int unsigned DATA_BITS = 8;

  // Bit time in system clocks
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned DEF_BAUD = 19_200;

  localparam logic LINE_IDLE = 1'h1;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [1:0] SYNC_IDLE = 2'h3;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [3:0] BIT_ZERO = 4'h0;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_START = 2'b01,
    TX_BITS = 2'b10,
    TX_STOP = 2'b11
  } tx_state_t;

  // Software side control strobes and levels
  typedef struct packed {
    logic async_mode;
    logic tx_enable;
    logic wake_set;
    logic send_break_set;
    logic hold_write;
    logic [7:0] hold_data;
    logic data_read;
  } sw_ctrl_t;

  // Status shown to software
  typedef struct packed {
    logic wake_on_edge_enable;
    logic send_break_ctrl;
    logic receive_complete_flag;
    logic transmit_buffer_empty_flag;
    logic shifter_empty_status;
  } sw_stat_t;

endpackage

/* verilog/sleep_wake_latch.sv */
`timescale 1ns/1ps
// Latches a falling rx edge while clocks are stopped; resynchronised on wake
module sleep_wake_latch (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Arming and line
  input wire logic armed,
  input wire logic serial_rx_pin,
  input wire logic ack,
  // Event level in clk_sys domain
  output logic event_sync
);

  typedef struct packed {
    logic s1;
    logic s2;
  } sync_t;

  logic arm_n;
  logic latched;
  sync_t st_q;
  sync_t st_d;

  assign arm_n = ~armed | ack;

  // Async catch of first falling edge [RULE23]
  always_ff @(negedge serial_rx_pin or posedge arm_n) begin
    if (arm_n) begin
      latched <= 1'b0;
    end else begin
      latched <= 1'b1;
    end
  end

  always_comb begin
    st_d = st_q;
    st_d.s1 = latched;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign event_sync = st_q.s2;

endmodule

/* verilog/uart_break_and_wakeup.sv */
`timescale 1ns/1ps
// Function
// (RULE1) Wake detection only works with the port in asynchronous mode; sleep stops clocks.
// (RULE2) Wake enable disables receive framing; receiver idles watching for a wake.
// (RULE3) A falling edge on the receive line is a wake event.
// (RULE4) A wake event sets the receive-complete flag, synchronously or asleep.
// (RULE5) Reading receive data clears the flag raised by the wake.
// (RULE6) First rising edge after the wake clears wake enable; reception resumes.
// (RULE7) Remote sends all-zero first character to a sleeping receiver.
// (RULE8) Remote keeps break long and idle after it for oscillator start.
// (RULE9) Software discards the byte read after a wake as dummy.
// (RULE10) Software checks receive idle before arming wake and sleeping.
// (RULE11) Break frame is a start bit, twelve zero bits, one stop bit.
// (RULE12) Send break plus transmit enable and loaded shifter sends zeros.
// (RULE13) Send break clears itself after the break stop bit.
// (RULE14) A byte written during the break is sent right after it.
// (RULE15) Shifter-empty status behaves for break as for any character.
// (RULE16) Software sends a LIN header: break, dummy byte, then 55h.
// (RULE17) Transmit-buffer-empty flag sets whenever the holding buffer empties.
// (RULE18) Software may receive a break at 9/13 of the baud rate.
// (RULE19) Wake-based break reception: two transitions, flag, then next byte, flag.
// (RULE20) Software may enable auto-baud once buffer-empty is seen.
// (RULE21) Software selects async mode by clearing sync and enabling the port.
// (RULE22) Receive line passes a two-stage synchroniser before edge detection.
// (RULE23) Asleep, an async latch catches the first falling edge, resynced later.
module uart_break_and_wakeup #(
  parameter int unsigned BIT_CLKS = brk_wake_pkg::CLK_HZ / brk_wake_pkg::DEF_BAUD
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Software control
  input wire brk_wake_pkg::sw_ctrl_t ctrl,
  // Serial line
  input wire logic serial_rx_pin,
  output logic serial_tx_line,
  // Hand-off to the base receiver
  output logic rx_framing_enable,
  // Status
  output brk_wake_pkg::sw_stat_t stat
);

  localparam logic [15:0] BIT_LAST = 16'(BIT_CLKS - 1);

  typedef struct packed {
    logic [1:0] rx_sync;
    logic rx_prev;
    logic wake_en;
    logic wake_seen;
    logic rc_flag;
    logic send_break;
    logic hold_full;
    logic [7:0] hold_byte;
    logic [7:0] shift;
    logic is_break;
    brk_wake_pkg::tx_state_t tx_st;
    logic [15:0] bit_cnt;
    logic [3:0] bit_idx;
    logic tx_line;
    logic framing_en;
    logic wake_ack;
    logic buf_empty;
    logic shifter_idle;
  } state_t;

  state_t st_q;
  state_t st_d;
  logic rx_s;
  logic fall;
  logic rise;
  logic sleep_event;
  logic bit_end;

  ////////////////////////////////////////////////////////////////////////
  // Bit timer: wraps at the end of each bit period
  function automatic logic [15:0] next_cnt(input logic [15:0] cnt);
    if (cnt == BIT_LAST) begin
      return brk_wake_pkg::CNT_ZERO;
    end
    return cnt + 16'h0001;
  endfunction

  // Last payload bit of the current frame
  function automatic logic frame_done(input logic brk, input logic [3:0] idx);
    if (brk) begin
      return idx == 4'(brk_wake_pkg::BREAK_ZERO_BITS - 1);
    end else begin
      return idx == 4'(brk_wake_pkg::DATA_BITS - 1);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Sleep-time edge catcher
  sleep_wake_latch u_latch (
    .clk_sys(clk_sys),
    .srst(srst),
    .armed(st_q.wake_en & ~st_q.wake_seen),
    .serial_rx_pin(serial_rx_pin),
    .ack(st_q.wake_ack),
    .event_sync(sleep_event)
  );

  assign rx_s = st_q.rx_sync[1];
  assign fall = st_q.rx_prev & ~rx_s;
  assign rise = ~st_q.rx_prev & rx_s;
  assign bit_end = (st_q.bit_cnt == BIT_LAST);

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    st_d = st_q;
    st_d.rx_sync = {st_q.rx_sync[0], serial_rx_pin}; // [RULE22]
    st_d.rx_prev = rx_s;
    st_d.wake_ack = 1'b0;

    // Read clears the flag; a wake in the same cycle sets it again [RULE5]
    if (ctrl.data_read) begin
      st_d.rc_flag = 1'b0;
    end

    // Wake detection
    if (ctrl.wake_set && ctrl.async_mode) begin
      st_d.wake_en = 1'b1; // [RULE1]
      st_d.wake_seen = 1'b0;
    end
    if (st_q.wake_en && ctrl.async_mode) begin
      if (!st_q.wake_seen && (fall || sleep_event)) begin
        st_d.wake_seen = 1'b1; // [RULE3]
        st_d.wake_ack = 1'b1;
        st_d.rc_flag = 1'b1; // [RULE4] [RULE19]
      end else if (st_q.wake_seen && rise) begin
        // A fresh arm in the same cycle keeps wake enabled
        st_d.wake_en = ctrl.wake_set; // [RULE6]
        st_d.wake_seen = 1'b0;
      end
    end
    // Framing off while armed; back on after end of break [RULE2] [RULE19]
    st_d.framing_en = ~st_d.wake_en;

    // Transmit control
    if (ctrl.send_break_set) begin
      st_d.send_break = 1'b1;
    end
    if (ctrl.hold_write) begin
      st_d.hold_full = 1'b1; // [RULE14]
      st_d.hold_byte = ctrl.hold_data;
    end

    st_d.bit_cnt = next_cnt(st_q.bit_cnt);
    case (st_q.tx_st)
      brk_wake_pkg::TX_IDLE: begin
        st_d.bit_cnt = brk_wake_pkg::CNT_ZERO;
        st_d.tx_line = brk_wake_pkg::LINE_IDLE;
        if (st_q.hold_full && ctrl.tx_enable) begin
          st_d.hold_full = ctrl.hold_write; // [RULE17]
          st_d.is_break = st_d.send_break; // [RULE12]
          st_d.shift = st_d.send_break ? brk_wake_pkg::BYTE_ZERO : st_q.hold_byte;
          st_d.bit_idx = brk_wake_pkg::BIT_ZERO;
          st_d.tx_line = 1'b0;
          st_d.tx_st = brk_wake_pkg::TX_START;
        end
      end
      brk_wake_pkg::TX_START: begin
        if (bit_end) begin
          st_d.tx_st = brk_wake_pkg::TX_BITS;
          st_d.tx_line = st_q.shift[0];
        end
      end
      brk_wake_pkg::TX_BITS: begin
        if (bit_end) begin
          st_d.bit_idx = st_q.bit_idx + 4'h1;
          st_d.shift = {1'b0, st_q.shift[7:1]};
          if (frame_done(st_q.is_break, st_q.bit_idx)) begin
            st_d.tx_st = brk_wake_pkg::TX_STOP; // [RULE11]
            st_d.tx_line = brk_wake_pkg::LINE_IDLE;
          end else begin
            st_d.tx_line = st_q.is_break ? 1'b0 : st_q.shift[1];
          end
        end
      end
      brk_wake_pkg::TX_STOP: begin
        if (bit_end) begin
          st_d.tx_st = brk_wake_pkg::TX_IDLE;
          if (st_q.is_break) begin
            // A set from software in this cycle wins over the clear
            st_d.send_break = ctrl.send_break_set; // [RULE13]
            st_d.is_break = 1'b0;
          end
        end
      end
      default: begin
        st_d.tx_st = brk_wake_pkg::TX_IDLE;
      end
    endcase

    // Status copies so every output leaves a flop
    st_d.buf_empty = ~st_d.hold_full; // [RULE17]
    st_d.shifter_idle = (st_d.tx_st == brk_wake_pkg::TX_IDLE); // [RULE15]
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_q <= '0;
      st_q.rx_sync <= brk_wake_pkg::SYNC_IDLE;
      st_q.rx_prev <= brk_wake_pkg::LINE_IDLE;
      st_q.tx_line <= brk_wake_pkg::LINE_IDLE;
      st_q.framing_en <= 1'b1;
      st_q.buf_empty <= 1'b1;
      st_q.shifter_idle <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs, all from flops
  assign serial_tx_line = st_q.tx_line;
  assign rx_framing_enable = st_q.framing_en;
  assign stat = '{
    wake_on_edge_enable: st_q.wake_en,
    send_break_ctrl: st_q.send_break,
    receive_complete_flag: st_q.rc_flag,
    transmit_buffer_empty_flag: st_q.buf_empty, // [RULE17]
    shifter_empty_status: st_q.shifter_idle // [RULE15]
  };

endmodule

/* verification/uart_brk_sva.sv */
`timescale 1ns/1ps
module uart_brk_sva #(
  parameter int unsigned BIT_CLKS = 4
) (
  // Watched ports
  input wire logic clk_sys,
  input wire logic srst,
  input wire brk_wake_pkg::sw_ctrl_t ctrl,
  input wire logic serial_rx_pin,
  input wire logic serial_tx_line,
  input wire logic rx_framing_enable,
  input wire brk_wake_pkg::sw_stat_t stat
);
  localparam int unsigned LOW_MAX = brk_wake_pkg::BREAK_LOW_BITS * BIT_CLKS;
  logic wake_en, rc_flag, brk_on;
  logic [31:0] low_q;
  assign wake_en = stat.wake_on_edge_enable;
  assign rc_flag = stat.receive_complete_flag;
  assign brk_on = stat.send_break_ctrl;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // Length of the current low run on the tx line
  always_ff @(posedge clk_sys) begin
    low_q <= (srst || serial_tx_line) ? 32'h0000_0000 : low_q + 32'h0000_0001;
  end
  wake_arm_a: assert property (ctrl.wake_set && ctrl.async_mode |=> wake_en)
    else $error("wake enable not armed");
  sync_only_a: assert property (ctrl.wake_set && !ctrl.async_mode && !wake_en |=> !wake_en)
    else $error("wake armed outside async mode");
  no_frame_a: assert property (wake_en |-> !rx_framing_enable)
    else $error("framing active while wake armed");
  flag_cause_a: assert property ($rose(rc_flag) |-> $past(wake_en))
    else $error("receive flag without wake");
  flag_clear_a: assert property ($fell(rc_flag) |-> $past(ctrl.data_read))
    else $error("receive flag cleared without read");
  wake_end_a: assert property ($fell(wake_en) |-> $past(serial_rx_pin, 2))
    else $error("wake enable cleared without rising line");
  brk_stop_a: assert property ($fell(brk_on) |-> $past(serial_tx_line))
    else $error("send break cleared before stop bit");
  brk_len_a: assert property (low_q <= LOW_MAX)
    else $error("tx low longer than a break");
  idle_high_a: assert property (stat.shifter_empty_status |-> serial_tx_line)
    else $error("tx line low while shifter empty");
  cover property ($rose(rc_flag));
  cover property ($fell(wake_en));
  cover property ($fell(brk_on));
endmodule
bind uart_break_and_wakeup uart_brk_sva #(.BIT_CLKS(BIT_CLKS)) u_uart_brk_sva (
  .clk_sys(clk_sys), .srst(srst), .ctrl(ctrl), .serial_rx_pin(serial_rx_pin),
  .serial_tx_line(serial_tx_line), .rx_framing_enable(rx_framing_enable), .stat(stat));

/* verification/remote_node.sv */
`timescale 1ns/1ps
module remote_node #(
  parameter int unsigned BIT_CLKS = 4
) (
  // Clock
  input wire logic clk_sys,
  // Start of a break-length low on the rx line (start bit plus twelve zeros)
  input wire logic fire,
  output logic serial_rx_pin
);
  int unsigned left_q = 0;
  always @(posedge clk_sys) begin
    if (fire) begin
      left_q <= brk_wake_pkg::BREAK_LOW_BITS * BIT_CLKS;
    end else if (left_q != 0) begin
      left_q <= left_q - 1;
    end
  end
  assign serial_rx_pin = (left_q == 0);
endmodule

/* verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  localparam int unsigned BC = 4;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic fire = 1'b0;
  logic serial_rx_pin, serial_tx_line, rx_framing_enable;
  logic [7:0] got;
  brk_wake_pkg::sw_ctrl_t ctrl = '0;
  brk_wake_pkg::sw_stat_t stat;
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;
  always #2.5 clk_sys = ~clk_sys;
  uart_break_and_wakeup #(.BIT_CLKS(BC)) u_uart_break_and_wakeup (.clk_sys(clk_sys),
    .srst(srst), .ctrl(ctrl), .serial_rx_pin(serial_rx_pin), .serial_tx_line(serial_tx_line),
    .rx_framing_enable(rx_framing_enable), .stat(stat));
  remote_node #(.BIT_CLKS(BC)) u_remote_node (.clk_sys(clk_sys), .fire(fire),
    .serial_rx_pin(serial_rx_pin));
  task automatic give_verdict();
    if (bad_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge clk_sys);
  endtask
  task automatic chk(input logic ok, input string what);
    checks_done++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask
  task automatic wait_low();
    for (int i = 0; i < 40 && serial_tx_line !== 1'b0; i++) tick(1);
  endtask
  task automatic t_reset();
    chk(stat === 5'h03 && serial_tx_line === 1'b1 && rx_framing_enable === 1'b1, "reset");
  endtask
  task automatic t_wake(input logic async);
    ctrl.async_mode = async;
    ctrl.wake_set = 1'b1;
    tick(1);
    ctrl.wake_set = 1'b0;
    tick(1);
    chk(stat.wake_on_edge_enable === async, "arm");
    if (async) begin
      chk(rx_framing_enable === 1'b0, "framing");
      fire = 1'b1;
      tick(1);
      fire = 1'b0;
      tick(6);
      chk(stat.receive_complete_flag === 1'b1, "wake flag");
      ctrl.data_read = 1'b1;
      tick(1);
      ctrl.data_read = 1'b0;
      tick(2);
      chk(stat.receive_complete_flag === 1'b0, "read clear");
      chk(stat.wake_on_edge_enable === 1'b1, "armed in break");
      tick(50);
      chk(stat.wake_on_edge_enable === 1'b0 && rx_framing_enable === 1'b1, "end");
    end
  endtask
  task automatic t_break();
    ctrl.tx_enable = 1'b1;
    ctrl.send_break_set = 1'b1;
    tick(1);
    ctrl.send_break_set = 1'b0;
    ctrl.hold_write = 1'b1;
    ctrl.hold_data = 8'hA5;
    tick(1);
    ctrl.hold_write = 1'b0;
    wait_low();
    chk(stat.send_break_ctrl === 1'b1 && stat.shifter_empty_status === 1'b0, "busy");
    chk(stat.transmit_buffer_empty_flag === 1'b1, "buffer empty");
    ctrl.hold_write = 1'b1;
    ctrl.hold_data = 8'h55;
    n = 0;
    while (serial_tx_line === 1'b0 && n < 99) begin
      n++;
      tick(1);
      ctrl.hold_write = 1'b0;
    end
    chk(n == brk_wake_pkg::BREAK_LOW_BITS * BC, "break length");
    wait_low();
    chk(stat.send_break_ctrl === 1'b0, "break clear");
    tick(2);
    for (int b = 0; b < 8; b++) begin
      tick(BC);
      got[b] = serial_tx_line;
    end
    chk(got === 8'h55, "sync byte");
    tick(2 * BC);
    chk(stat.shifter_empty_status === 1'b1, "idle");
    chk(stat.transmit_buffer_empty_flag === 1'b1, "idle buffer");
    ctrl.tx_enable = 1'b0;
    ctrl.hold_write = 1'b1;
    ctrl.hold_data = 8'h3C;
    tick(1);
    ctrl.hold_write = 1'b0;
    tick(3);
    chk(serial_tx_line === 1'b1 && stat.shifter_empty_status === 1'b1, "tx disabled");
    chk(stat.transmit_buffer_empty_flag === 1'b0, "buffer held");
    ctrl.tx_enable = 1'b1;
    wait_low();
    chk(stat.shifter_empty_status === 1'b0 && stat.send_break_ctrl === 1'b0, "plain");
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      give_verdict();
    end
  end
  initial begin
    tick(4);
    srst = 1'b0;
    t_reset();
    t_wake(1'b0);
    t_wake(1'b1);
    t_break();
    give_verdict();
  end
endmodule
